// *** common/pos_pkg.sv ***
// package: register map, commands, timing and types of the positioning engine
package pos_pkg;
   // timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int ACCEL_TICK_NS = 10000;
   localparam int ACCEL_TICK_CYCLES =
      (ACCEL_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] ACCEL_TICK_LAST = 8'(ACCEL_TICK_CYCLES - 1);

   // register byte addresses
   localparam logic [7:0] ADDR_CMD = 8'h00;
   localparam logic [7:0] ADDR_DATA = 8'h04;
   localparam logic [7:0] ADDR_TARGET = 8'h08;
   localparam logic [7:0] ADDR_ACCEL = 8'h0C;
   localparam logic [7:0] ADDR_DECEL = 8'h10;
   localparam logic [7:0] ADDR_INIT_SPEED = 8'h14;
   localparam logic [7:0] ADDR_DRIVE_SPEED = 8'h18;
   localparam logic [7:0] ADDR_MODE3 = 8'h1C;
   localparam logic [7:0] ADDR_OFFSET = 8'h20;
   localparam logic [7:0] ADDR_LOGICAL = 8'h24;
   localparam logic [7:0] ADDR_REAL = 8'h28;
   localparam logic [7:0] ADDR_MANUAL = 8'h2C;

   // command codes
   localparam logic [7:0] CMD_SET_MANUAL = 8'h07;
   localparam logic [7:0] CMD_REL = 8'h50;
   localparam logic [7:0] CMD_CREL = 8'h51;
   localparam logic [7:0] CMD_CONT_PLUS = 8'h52;
   localparam logic [7:0] CMD_CONT_MINUS = 8'h53;
   localparam logic [7:0] CMD_ABS = 8'h54;
   localparam logic [7:0] CMD_STOP_DECEL = 8'h5E;
   localparam logic [7:0] CMD_STOP_INSTANT = 8'h5F;

   // mode register three fields
   localparam int MODE_MANUAL_BIT = 0;
   localparam int MODE_ACCEL_BIT = 1;
   localparam int MODE_STOP_EN_BIT = 2;

   // reset values
   localparam logic [31:0] REG_RESET = 32'h0000_0000;
   localparam logic [31:0] OFFSET_RESET = 32'h0000_0000;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic pulse;
      logic dir_minus;
   } motor_out_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ACCEL = 2'b01,
      ST_CONST = 2'b11,
      ST_DECEL = 2'b10
   } drive_state_t;

   typedef enum logic [1:0] {
      KIND_REL = 2'b00,
      KIND_CREL = 2'b01,
      KIND_ABS = 2'b10,
      KIND_CONT = 2'b11
   } drive_kind_t;
endpackage

// *** design/fixed_pulse_positioning.sv ***
// design: one-axis pulse positioning engine with register port
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

//Overview of operation
// - fixed drives emit exactly the target count, then end
// - continuous drives run until a stop command or enabled stop input
// - relative drive: positive count moves plus, negative moves minus
// - symmetric profile decelerates once remaining drops to accel pulses or below
// - command 50h starts a relative drive
// - absolute drive takes direction and count from target minus position
// - command 54h starts an absolute drive
// - counter-relative drive moves opposite to the sign of the count
// - command 51h starts a counter-relative drive
// - a new target during relative drives applies to the running drive
// - target raised during deceleration makes the drive accelerate again
// - new target below pulses already emitted halts output at once
// - target change in S-curve deceleration need not follow the curve
// - absolute drives ignore target rewrites
// - deceleration point is computed automatically unless manual mode
// - manual mode decelerates at the host supplied point
// - logical counter counts drive pulses, real counter counts encoder
// - mode three bit 0 selects manual mode; command 07h sets the point
// - commands 52h and 53h start plus and minus continuous drives
// - deceleration offset resets to zero; positive offset decelerates early
module fixed_pulse_positioning (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // register port
   input wire pos_pkg::reg_req_t bus,
   output logic [31:0] rdata,
   // encoder and stop input
   input wire logic enc_up,
   input wire logic enc_down,
   input wire logic stop_in,
   // motor driver side
   output pos_pkg::motor_out_t motor,
   output logic busy
);
   import pos_pkg::*;

   function automatic logic hit(input reg_req_t r, input logic [7:0] a);
      return r.addr == a;
   endfunction

   function automatic logic [31:0] mag(input logic [31:0] v);
      return v[31] ? 32'(-v) : v;
   endfunction

   logic [31:0] target, data_hold, decel_offset, manual_point;
   logic [15:0] accel_rate, decel_rate;
   logic [15:0] initial_speed_value, drive_speed_value;
   logic [2:0] mode_register_three;
   logic [31:0] logical_pos, real_pos, emitted, tabs, accel_cnt;
   logic [15:0] speed, acc;
   logic [7:0] tick_cnt;
   logic dir_minus, stopping, pulse_q;
   drive_state_t state;
   drive_kind_t kind;

   logic cmd_wr, tgt_wr, start_cmd, instant, fixed, rel_kind;
   logic manual, accel_en, tick, pulse_now, decel_req, end_now;
   logic override_halt, auto_hit, target_sign, abs_diff_sign;
   logic [7:0] cmd;
   logic [31:0] remaining, abs_diff;
   logic [16:0] next_acc, up_sum;
   logic [15:0] eff_decel;
   logic signed [33:0] auto_limit;

   assign cmd = bus.wdata[7:0];
   assign cmd_wr = bus.wr && hit(bus, ADDR_CMD);
   assign tgt_wr = bus.wr && hit(bus, ADDR_TARGET);
   assign busy = state != ST_IDLE;
   // drive commands while busy are ignored; only stops and command 07h act then
   assign start_cmd = cmd_wr && !busy && (cmd == CMD_REL ||
      cmd == CMD_CREL || cmd == CMD_ABS || cmd == CMD_CONT_PLUS ||
      cmd == CMD_CONT_MINUS);
   assign instant = cmd_wr && busy && cmd == CMD_STOP_INSTANT;
   assign fixed = kind != KIND_CONT;
   assign rel_kind = kind == KIND_REL || kind == KIND_CREL;
   assign manual = mode_register_three[MODE_MANUAL_BIT];
   assign accel_en = mode_register_three[MODE_ACCEL_BIT];
   assign target_sign = target[31];
   assign abs_diff = target - logical_pos;
   assign abs_diff_sign = abs_diff[31];
   assign remaining = tabs - emitted;
   assign tick = tick_cnt == ACCEL_TICK_LAST;
   assign eff_decel = (decel_rate == 16'h0000) ? accel_rate : decel_rate;
   assign next_acc = {1'b0, acc} + {1'b0, speed};
   assign up_sum = {1'b0, speed} + {1'b0, accel_rate};
   // a fixed drive never emits past its count
   assign pulse_now = busy && next_acc[16] && !override_halt &&
      !(fixed && remaining == 32'h0000_0000);
   // a target at or under the emitted count stops at once; the pulse due in
   // that cycle is dropped too, so the count never passes the new target
   assign override_halt = tgt_wr && busy && rel_kind &&
      mag(bus.wdata) <= emitted;
   // offset is signed; a negative one can cut the ramp short
   assign auto_limit = $signed({2'b00, accel_cnt}) +
      $signed({{2{decel_offset[31]}}, decel_offset});
   assign auto_hit = $signed({2'b00, remaining}) <= auto_limit;
   // S-curve shaping is not modelled, so a rewrite never tracks it
   assign decel_req = accel_en && (stopping || (fixed && (manual ?
      remaining <= manual_point : auto_hit)));
   assign end_now = busy && (instant || override_halt ||
      (fixed && remaining == 32'h0000_0000) ||
      (stopping && (!accel_en || (state == ST_DECEL &&
      speed <= initial_speed_value))));
   assign motor = '{pulse: pulse_q, dir_minus: dir_minus};

   // parameter registers
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         target <= REG_RESET;
         data_hold <= REG_RESET;
         accel_rate <= REG_RESET[15:0];
         decel_rate <= REG_RESET[15:0];
         initial_speed_value <= REG_RESET[15:0];
         drive_speed_value <= REG_RESET[15:0];
         mode_register_three <= REG_RESET[2:0];
         decel_offset <= OFFSET_RESET;
         manual_point <= REG_RESET;
      end else if (bus.wr) begin
         if (hit(bus, ADDR_DATA)) begin
            data_hold <= bus.wdata;
         end else if (hit(bus, ADDR_TARGET)) begin
            target <= bus.wdata;
         end else if (hit(bus, ADDR_ACCEL)) begin
            accel_rate <= bus.wdata[15:0];
         end else if (hit(bus, ADDR_DECEL)) begin
            decel_rate <= bus.wdata[15:0];
         end else if (hit(bus, ADDR_INIT_SPEED)) begin
            initial_speed_value <= bus.wdata[15:0];
         end else if (hit(bus, ADDR_DRIVE_SPEED)) begin
            drive_speed_value <= bus.wdata[15:0];
         end else if (hit(bus, ADDR_MODE3)) begin
            mode_register_three <= bus.wdata[2:0];
         end else if (hit(bus, ADDR_OFFSET)) begin
            decel_offset <= bus.wdata;
         end else if (cmd_wr && cmd == CMD_SET_MANUAL) begin
            manual_point <= data_hold;
         end
      end
   end

   // drive kind, direction and pulse target
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         kind <= KIND_REL;
         dir_minus <= 1'b0;
         tabs <= REG_RESET;
      end else if (start_cmd) begin
         if (cmd == CMD_REL) begin
            kind <= KIND_REL;
            dir_minus <= target[31];
            tabs <= mag(target);
         end else if (cmd == CMD_CREL) begin
            kind <= KIND_CREL;
            dir_minus <= ~target[31];
            tabs <= mag(target);
         end else if (cmd == CMD_ABS) begin
            kind <= KIND_ABS;
            dir_minus <= abs_diff[31];
            tabs <= mag(abs_diff);
         end else begin
            kind <= KIND_CONT;
            dir_minus <= cmd == CMD_CONT_MINUS;
            tabs <= REG_RESET;
         end
      end else if (tgt_wr && busy && rel_kind && !override_halt) begin
         // absolute drives fall through and keep their count
         tabs <= mag(bus.wdata);
      end
   end

   // drive sequencer
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (start_cmd) begin
                  state <= accel_en ? ST_ACCEL : ST_CONST;
               end
            end
            ST_ACCEL, ST_CONST: begin
               if (end_now) begin
                  state <= ST_IDLE;
               end else if (decel_req) begin
                  state <= ST_DECEL;
               end else if (state == ST_ACCEL &&
                            speed >= drive_speed_value) begin
                  state <= ST_CONST;
               end
            end
            ST_DECEL: begin
               if (end_now) begin
                  state <= ST_IDLE;
               end else if (!decel_req) begin
                  state <= ST_ACCEL;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // stop request latch; cleared only when the drive has ended
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         stopping <= 1'b0;
      end else if (!busy) begin
         stopping <= 1'b0;
      end else if ((cmd_wr && cmd == CMD_STOP_DECEL) ||
                   (mode_register_three[MODE_STOP_EN_BIT] && stop_in)) begin
         stopping <= 1'b1;
      end
   end

   // ramp tick divider
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         tick_cnt <= 8'h00;
      end else if (tick || !busy) begin
         tick_cnt <= 8'h00;
      end else begin
         tick_cnt <= tick_cnt + 8'h01;
      end
   end

   // speed ramp; units are 1/65536 pulse per clock
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         speed <= 16'h0000;
      end else if (start_cmd) begin
         speed <= accel_en ? initial_speed_value : drive_speed_value;
      end else if (!busy) begin
         speed <= 16'h0000;
      end else if (state == ST_CONST && !accel_en) begin
         speed <= drive_speed_value;
      end else if (tick && state == ST_ACCEL) begin
         speed <= (up_sum >= {1'b0, drive_speed_value}) ?
            drive_speed_value : up_sum[15:0];
      end else if (tick && state == ST_DECEL) begin
         speed <= ({1'b0, speed} <= {1'b0, initial_speed_value} +
            {1'b0, eff_decel}) ? initial_speed_value : speed - eff_decel;
      end
   end

   // pulse phase accumulator and emitted counters
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         acc <= 16'h0000;
         pulse_q <= 1'b0;
         emitted <= REG_RESET;
         accel_cnt <= REG_RESET;
      end else if (start_cmd) begin
         acc <= 16'h0000;
         pulse_q <= 1'b0;
         emitted <= REG_RESET;
         accel_cnt <= REG_RESET;
      end else begin
         acc <= busy ? next_acc[15:0] : 16'h0000;
         pulse_q <= pulse_now;
         if (pulse_now) begin
            emitted <= emitted + 32'h0000_0001;
            if (state == ST_ACCEL) begin
               accel_cnt <= accel_cnt + 32'h0000_0001;
            end
         end
      end
   end

   // position counters; a pulse wins over a software write
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         logical_pos <= REG_RESET;
      end else if (pulse_now) begin
         logical_pos <= dir_minus ? logical_pos - 32'h0000_0001 :
            logical_pos + 32'h0000_0001;
      end else if (bus.wr && hit(bus, ADDR_LOGICAL)) begin
         logical_pos <= bus.wdata;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         real_pos <= REG_RESET;
      end else if (enc_up != enc_down) begin
         real_pos <= enc_up ? real_pos + 32'h0000_0001 :
            real_pos - 32'h0000_0001;
      end else if (bus.wr && hit(bus, ADDR_REAL)) begin
         real_pos <= bus.wdata;
      end
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rdata <= REG_RESET;
      end else if (!bus.rd) begin
         rdata <= REG_RESET;
      end else if (hit(bus, ADDR_CMD)) begin
         rdata <= {27'h0, stopping, dir_minus, state, busy};
      end else if (hit(bus, ADDR_DATA)) begin
         rdata <= data_hold;
      end else if (hit(bus, ADDR_TARGET)) begin
         rdata <= target;
      end else if (hit(bus, ADDR_ACCEL)) begin
         rdata <= {16'h0000, accel_rate};
      end else if (hit(bus, ADDR_DECEL)) begin
         rdata <= {16'h0000, decel_rate};
      end else if (hit(bus, ADDR_INIT_SPEED)) begin
         rdata <= {16'h0000, initial_speed_value};
      end else if (hit(bus, ADDR_DRIVE_SPEED)) begin
         rdata <= {16'h0000, drive_speed_value};
      end else if (hit(bus, ADDR_MODE3)) begin
         rdata <= {29'h0, mode_register_three};
      end else if (hit(bus, ADDR_OFFSET)) begin
         rdata <= decel_offset;
      end else if (hit(bus, ADDR_LOGICAL)) begin
         rdata <= logical_pos;
      end else if (hit(bus, ADDR_REAL)) begin
         rdata <= real_pos;
      end else if (hit(bus, ADDR_MANUAL)) begin
         rdata <= manual_point;
      end else begin
         rdata <= REG_RESET;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   property p_rel_start;
      start_cmd && cmd == CMD_REL |=> busy && dir_minus == $past(target_sign);
   endproperty
   a_rel_start: assert property (p_rel_start)
      else $error("relative drive start or direction wrong");

   property p_crel_dir;
      start_cmd && cmd == CMD_CREL |=> dir_minus == !$past(target_sign);
   endproperty
   a_crel_dir: assert property (p_crel_dir)
      else $error("counter-relative direction wrong");

   property p_abs_dir;
      start_cmd && cmd == CMD_ABS |=>
         kind == KIND_ABS && dir_minus == $past(abs_diff_sign);
   endproperty
   a_abs_dir: assert property (p_abs_dir)
      else $error("absolute drive direction wrong");

   property p_fixed_bound;
      busy && fixed |-> emitted <= tabs;
   endproperty
   a_fixed_bound: assert property (p_fixed_bound)
      else $error("emitted more pulses than the target");

   property p_fixed_end;
      busy && fixed && remaining == 32'h0000_0000 |=> !busy ##1 !pulse_q;
   endproperty
   a_fixed_end: assert property (p_fixed_end)
      else $error("fixed drive did not end on its count");

   property p_logical;
      pulse_now && !dir_minus |=> logical_pos == $past(logical_pos) + 1;
   endproperty
   a_logical: assert property (p_logical)
      else $error("logical counter missed a plus pulse");

   property p_halt;
      override_halt |=> !busy && !pulse_q;
   endproperty
   a_halt: assert property (p_halt)
      else $error("drive did not halt on a short target");

   property p_abs_hold;
      busy && kind == KIND_ABS && tgt_wr |=> $stable(tabs);
   endproperty
   a_abs_hold: assert property (p_abs_hold)
      else $error("absolute drive took a target rewrite");

   property p_reaccel;
      state == ST_DECEL && !decel_req && !end_now |=> state == ST_ACCEL;
   endproperty
   a_reaccel: assert property (p_reaccel)
      else $error("no re-acceleration after target raise");

   property p_manual;
      (state == ST_ACCEL || state == ST_CONST) && accel_en && manual &&
         fixed && !end_now && remaining <= manual_point |=>
         state == ST_DECEL;
   endproperty
   a_manual: assert property (p_manual)
      else $error("manual deceleration point not honoured");

   property p_cont_runs;
      busy && !fixed && !stopping && !instant |=> busy;
   endproperty
   a_cont_runs: assert property (p_cont_runs)
      else $error("continuous drive ended without a stop");

   c_rel_done: cover property (busy && kind == KIND_REL ##1 !busy);
   c_reaccel: cover property (state == ST_DECEL ##1 state == ST_ACCEL);
   c_cont_stop: cover property (stopping && kind == KIND_CONT ##1 !busy);
endmodule // fixed_pulse_positioning

`default_nettype wire

// *** test/motor_model.sv ***
// behavioural motor driver: counts steps and echoes them as encoder counts
`timescale 1ns/1ps
`default_nettype none
module motor_model (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // steps from the engine
   input wire pos_pkg::motor_out_t motor,
   // encoder feedback and observation
   output logic enc_up,
   output logic enc_down,
   output logic [31:0] pulses,
   output logic [31:0] pos
);
   import pos_pkg::*;
   // encoder lags a cycle, so the real counter cannot copy the logical one
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         enc_up <= 1'b0;
         enc_down <= 1'b0;
         pulses <= '0;
         pos <= '0;
      end else begin
         enc_up <= motor.pulse & ~motor.dir_minus;
         enc_down <= motor.pulse & motor.dir_minus;
         if (motor.pulse) begin
            pulses <= pulses + 32'h1;
            pos <= motor.dir_minus ? pos - 32'h1 : pos + 32'h1;
         end
      end
   end
endmodule // motor_model
`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench for the positioning engine with a motor model
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import pos_pkg::*;
   localparam int LIMIT = 90000;
   logic clock = 1'b0;
   logic rst = 1'b1;
   reg_req_t bus = '0;
   logic [31:0] rdata;
   logic enc_up;
   logic enc_down;
   logic stop_in = 1'b0;
   motor_out_t motor;
   logic busy;
   logic [31:0] pulses;
   logic [31:0] pos;
   int errors = 0;
   int check_count = 0;
   int cycles = 0;
   logic [31:0] rd_val;
   logic [31:0] p0;
   logic [31:0] x0;
   logic [31:0] seed;
   logic signed [31:0] n;
   logic signed [31:0] tgt;
   logic [7:0] ra [6] = '{ADDR_CMD, ADDR_OFFSET, ADDR_LOGICAL, ADDR_REAL,
      ADDR_MANUAL, 8'h30};

   fixed_pulse_positioning fixed_pulse_positioning_inst (.clock(clock),
      .rst(rst), .bus(bus), .rdata(rdata), .enc_up(enc_up),
      .enc_down(enc_down), .stop_in(stop_in), .motor(motor), .busy(busy));
   motor_model motor_model_inst (.clock(clock), .rst(rst), .motor(motor),
      .enc_up(enc_up), .enc_down(enc_down), .pulses(pulses), .pos(pos));

   always #20 clock = ~clock;

   task automatic end_sim;
      $display("checks=%0d errors=%0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles == LIMIT) begin
         errors++;
         $display("[FAIL] t=%0t cycles=%h exp=%h", $time, cycles, LIMIT);
         end_sim;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clock);
      bus <= '0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clock);
      bus <= '0;
      #1 d = rdata;
   endtask

   // a hang here is counted, then the sequence moves on
   task automatic wait_idle(input int lim);
      int k;
      k = 0;
      while (busy !== 1'b0 && k < lim) begin
         @(posedge clock);
         #1 k++;
      end
      if (k >= lim) begin
         errors++;
         $display("[FAIL] t=%0t busy=%h exp=%h", $time, busy, 1'b0);
      end
      repeat (3) @(posedge clock);
   endtask

   task automatic wait_pulses(input logic [31:0] k, input int lim);
      int j;
      j = 0;
      while (pulses < k && j < lim) begin
         @(posedge clock);
         j++;
      end
   endtask

   function automatic logic [31:0] mag(input logic signed [31:0] v);
      return (v < 0) ? -v : v;
   endfunction

   // signed travel expected from a drive command
   function automatic logic [31:0] travel(input logic [7:0] c,
      input logic signed [31:0] v, input logic [31:0] at);
      case (c)
         CMD_CREL: return -v;
         CMD_ABS: return v - at;
         default: return v;
      endcase
   endfunction

   task automatic chk_pos;
      rd(ADDR_LOGICAL, rd_val);
      chk(rd_val, pos);
      rd(ADDR_REAL, rd_val);
      chk(rd_val, pos);
   endtask

   task automatic start(input logic [7:0] c, input logic signed [31:0] v);
      p0 = pulses;
      x0 = pos;
      wr(ADDR_TARGET, v);
      wr(ADDR_CMD, {24'h0, c});
      @(posedge clock);
      #1 chk(busy, 1'b1);
   endtask

   task automatic drive(input logic [7:0] c, input logic signed [31:0] v,
      input int lim);
      logic [31:0] d;
      d = travel(c, v, pos);
      start(c, v);
      wait_idle(lim);
      chk(pulses - p0, mag(d));
      chk(pos - x0, d);
      chk_pos();
   endtask

   initial begin
      seed = $urandom(32'hAA839925);
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      foreach (ra[i]) begin
         rd(ra[i], rd_val);
         chk(rd_val, REG_RESET);
      end
      wr(ADDR_OFFSET, 32'h5);
      rd(ADDR_OFFSET, rd_val);
      chk(rd_val, 32'h5);
      wr(ADDR_OFFSET, OFFSET_RESET);
      wr(ADDR_INIT_SPEED, 32'h8000);
      wr(ADDR_DRIVE_SPEED, 32'h8000);
      $display("test reset_values done");
      drive(CMD_REL, 32'sh1, 200);
      drive(CMD_CREL, -32'sh1, 200);
      for (int i = 0; i < 12; i++) begin
         n = $urandom_range(40, 1);
         if ($urandom_range(1, 0) == 1) n = -n;
         case (i % 3)
            0: drive(CMD_REL, n, 2000);
            1: drive(CMD_CREL, n, 2000);
            default: drive(CMD_ABS, pos + n, 2000);
         endcase
      end
      $display("test random_drives done");
      start(CMD_REL, -32'sh1E);
      wait_pulses(p0 + 32'hA, 2000);
      wr(ADDR_TARGET, -32'sh32);
      wait_idle(2000);
      chk(pulses - p0, 32'h32);
      start(CMD_REL, 32'sh28);
      wait_pulses(p0 + 32'h14, 2000);
      wr(ADDR_TARGET, 32'sh5);
      wait_idle(8);
      chk({31'h0, (pulses - p0) < 32'h28}, 32'h1);
      chk_pos();
      tgt = pos + 32'h1E;
      start(CMD_ABS, tgt);
      wait_pulses(p0 + 32'hA, 2000);
      wr(ADDR_TARGET, tgt + 32'h1E);
      wait_idle(2000);
      chk(pos, tgt);
      $display("test override done");
      wr(ADDR_CMD, {24'h0, CMD_CONT_MINUS});
      repeat (100) @(posedge clock);
      stop_in <= 1'b1;
      repeat (20) @(posedge clock);
      #1 chk(busy, 1'b1);
      chk(motor.dir_minus, 1'b1);
      wr(ADDR_MODE3, 32'h4);
      wait_idle(50);
      stop_in <= 1'b0;
      wr(ADDR_MODE3, 32'h0);
      x0 = pos;
      wr(ADDR_CMD, {24'h0, CMD_CONT_PLUS});
      repeat (100) @(posedge clock);
      #1 chk(motor.dir_minus, 1'b0);
      wr(ADDR_CMD, {24'h0, CMD_STOP_INSTANT});
      wait_idle(50);
      chk({31'h0, pos - x0 > 32'h20}, 32'h1);
      chk_pos();
      $display("test continuous done");
      wr(ADDR_ACCEL, 32'h400);
      wr(ADDR_INIT_SPEED, 32'h800);
      wr(ADDR_MODE3, 32'h2);
      drive(CMD_REL, 32'sh12C, 30000);
      start(CMD_REL, 32'sh12C);
      wait_pulses(p0 + 32'h122, 30000);
      wr(ADDR_TARGET, 32'sh258);
      repeat (300) @(posedge clock);
      rd(ADDR_CMD, rd_val);
      chk({30'h0, rd_val[2:1]}, {30'h0, ST_ACCEL});
      wait_idle(30000);
      chk(pulses - p0, 32'h258);
      wr(ADDR_DATA, 32'h64);
      wr(ADDR_CMD, {24'h0, CMD_SET_MANUAL});
      rd(ADDR_MANUAL, rd_val);
      chk(rd_val, 32'h64);
      wr(ADDR_MODE3, 32'h3);
      drive(CMD_REL, 32'sh96, 30000);
      // a decelerating stop with the ramp on must pass through deceleration
      wr(ADDR_CMD, {24'h0, CMD_CONT_PLUS});
      repeat (300) @(posedge clock);
      wr(ADDR_CMD, {24'h0, CMD_STOP_DECEL});
      rd(ADDR_CMD, rd_val);
      chk(rd_val, {27'h0, 1'b1, 1'b0, ST_DECEL, 1'b1});
      wait_idle(600);
      chk_pos();
      $display("test profiles done");
      end_sim;
   end
endmodule // testbench
`default_nettype wire
